/* File: rtl/isc_collector.sv */
// interrupt status collector: spare place for helpers of the collector top
// assumes nothing; the collector and its flag bank carry all of the logic

/* File: rtl/isc_flag_bank.sv */
// bank of sticky flags, one flip-flop per bit that the mask names
// assumes clear already gated by the user; set always beats clear
module isc_flag_bank
    import isc_pkg::*;
#(
    parameter logic [31:0] MASK = W1C_MASK
) (
    input wire logic clk,
    input wire logic reset,
    isc_flag_if.bank flags
);
    // one cell per bit; unmasked bits are constant zero
    for (genvar i = 0; i < 32; i++) begin : g_bit
        if (MASK[i]) begin : g_used
            logic q_reg;
            logic q_next;
            // a set arriving with the clear is kept [R3]
            always_comb begin
                q_next = flags.set[i] | (q_reg & ~flags.clear[i]);
            end
            // cleared by reset [R16]
            always_ff @(posedge clk or posedge reset) begin
                if (reset) begin
                    q_reg <= 1'b0;
                end else begin
                    q_reg <= q_next;
                end
            end
            assign flags.q[i] = q_reg;
        end else begin : g_none
            assign flags.q[i] = 1'b0;
        end
    end

    a_set_wins: assert property ( // [R3]
        @(posedge clk) disable iff (reset)
        1'b1 |=> ((($past(flags.set) & MASK) & ~flags.q) == 32'h00000000))
        else $error("flag set was lost");
endmodule

/* File: rtl/isc_flag_if.sv */
// set, clear and value vectors of the write-one-to-clear flag bank
// assumes one user drives set and clear, the bank drives the value
interface isc_flag_if;
    logic [31:0] set;
    logic [31:0] clear;
    logic [31:0] q;
    modport bank(input set, input clear, output q);
    modport user(output set, output clear, input q);
endinterface

/* File: rtl/isc_main.sv */
// top of the interrupt status collector: registers, flag sources, request
// assumes a synchronous register port; holdoff timer and sources are outside
// assumes reads and writes never share a cycle; a read answers one edge later

// Summary of operation
// R1: flags follow sources whatever the enables
// R2: flag reads one when condition met
// R3: writing one clears, zero leaves unchanged
// R4: enable bit rising sets software flag
// R5: ready flag set once after reset
// R6: bit 27 mirrors second phy event
// R7: bit 26 mirrors first phy event
// R8: timer wrap zero to all ones sets flag
// R9: power event sets power flag
// R10: power flag clears only after control bits clear
// R11: power request bypasses the holdoff interval
// R12: enable bit makes flag a request contributor
// R13: global state shows any enabled active flag
// R14: holdoff interval withholds the request pin
// R15: request is or of flags and enables
// R16: reset clears flags; read-only writes ignored
module isc_collector
    import isc_pkg::*;
#(
    parameter int TIMER_WIDTH = TIMER_W
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_wdata,
    input wire logic first_phy_event,
    input wire logic second_phy_event,
    input wire logic [TIMER_WIDTH-1:0] timer_count,
    input wire logic power_event_detect,
    input wire logic power_event_control_pending,
    input wire logic holdoff_active_state,
    output logic [31:0] reg_rdata,
    output logic reg_rvalid,
    output logic irq_request,
    output logic irq_global
);
    // write-one-to-clear flags live in the bank; the phy mirrors live here
    isc_flag_if w1c_bus();

    logic [31:0] enable_reg;
    logic [31:0] enable_next;
    logic [1:0] phy_mirror_reg;
    logic [1:0] phy_mirror_next;
    logic ready_seen_reg;
    logic ready_seen_next;
    logic timer_primed_reg;
    logic timer_primed_next;
    logic [TIMER_WIDTH-1:0] timer_prev_reg;
    logic [TIMER_WIDTH-1:0] timer_prev_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic rvalid_reg;
    logic rvalid_next;
    logic request_reg;
    logic request_next;
    logic global_reg;
    logic global_next;

    logic write_flags;
    logic write_enable;
    logic software_flag_enable;
    logic software_rise;
    logic timer_wrap;
    logic [31:0] set_vec;
    logic [31:0] clear_vec;
    logic [31:0] mirror_vec;
    logic [31:0] interrupt_flags;
    logic [31:0] active_vec;
    logic irq_line;
    logic power_line;

    // register port decode; the two offsets never overlap
    always_comb begin
        write_flags = reg_wr && (reg_addr == FLAGS_OFFSET);
        write_enable = reg_wr && (reg_addr == ENABLE_OFFSET);
    end

    // event detectors for the software and timer sources
    always_comb begin
        software_flag_enable = enable_reg[SW_BIT];
        // only a fresh 0 to 1 write counts, else a held enable would re-raise it
        software_rise = write_enable && reg_wdata[SW_BIT] && !software_flag_enable; // [R4]
        // primed guard keeps a stale zero after reset from faking a wrap
        timer_wrap = timer_primed_reg
            && (timer_prev_reg == {TIMER_WIDTH{1'b0}})
            && (timer_count == {TIMER_WIDTH{1'b1}}); // [R8]
    end

    // set requests into the sticky bank, one bit per source
    always_comb begin
        set_vec = 32'h00000000;
        set_vec[SW_BIT] = software_rise; // [R4]
        set_vec[READY_BIT] = !ready_seen_reg; // [R5]
        set_vec[TIMER_BIT] = timer_wrap; // [R8]
        set_vec[POWER_BIT] = power_event_detect; // [R9]
    end

    // host acknowledge; zeros and read-only positions fall out of the mask
    always_comb begin
        clear_vec = 32'h00000000;
        if (write_flags) begin
            clear_vec = reg_wdata & W1C_MASK; // [R3] [R16]
            // power flag refuses the clear while control bits still pend
            if (power_event_control_pending) begin
                clear_vec = clear_vec & ~POWER_MASK; // [R10]
            end
        end
    end

    // hand set and clear to the bank; the bank lets a set beat a clear
    assign w1c_bus.set = set_vec;
    assign w1c_bus.clear = clear_vec;

    isc_flag_bank #(
        .MASK(W1C_MASK)
    ) u_flag_bank (
        .clk(clk),
        .reset(reset),
        .flags(w1c_bus)
    );

    // next values of the source trackers
    always_comb begin
        phy_mirror_next = {second_phy_event, first_phy_event}; // [R6] [R7]
        ready_seen_next = 1'b1; // [R5]
        timer_primed_next = 1'b1;
        timer_prev_next = timer_count;
    end

    // source trackers; the mirrors cost one cycle of lag behind the phys
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            phy_mirror_reg <= 2'h0; // [R16]
            ready_seen_reg <= 1'b0;
            timer_primed_reg <= 1'b0;
            timer_prev_reg <= {TIMER_WIDTH{1'b0}};
        end else begin
            phy_mirror_reg <= phy_mirror_next;
            ready_seen_reg <= ready_seen_next;
            timer_primed_reg <= timer_primed_next;
            timer_prev_reg <= timer_prev_next;
        end
    end

    // the visible flag word: sticky flags plus read-only mirrors
    always_comb begin
        mirror_vec = 32'h00000000;
        mirror_vec[PHY_B_BIT] = phy_mirror_reg[1]; // [R6]
        mirror_vec[PHY_A_BIT] = phy_mirror_reg[0]; // [R7]
        // reserved bits stay zero since neither source drives them
        interrupt_flags = (w1c_bus.q & W1C_MASK) | (mirror_vec & MIRROR_MASK); // [R1] [R2] [R15]
    end

    // enable register; only defined enable bits can be written
    always_comb begin
        enable_next = enable_reg;
        if (write_enable) begin
            enable_next = reg_wdata & ENABLE_MASK; // [R12]
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            enable_reg <= ENABLE_RESET;
        end else begin
            enable_reg <= enable_next;
        end
    end

    // request logic; enables gate the request, never the flags
    always_comb begin
        active_vec = interrupt_flags & enable_reg; // [R12]
        irq_line = |active_vec; // [R15]
        power_line = |(active_vec & POWER_MASK); // [R11]
        global_next = irq_line; // [R13]
        // power events skip the holdoff so a wake-up is never delayed
        request_next = (irq_line && !holdoff_active_state) || power_line; // [R11] [R14]
    end

    // read mux; unknown offsets read as zero rather than aliasing
    always_comb begin
        rdata_next = rdata_reg;
        rvalid_next = reg_rd;
        if (reg_rd) begin
            if (reg_addr == FLAGS_OFFSET) begin
                rdata_next = interrupt_flags; // [R2]
            end else if (reg_addr == ENABLE_OFFSET) begin
                rdata_next = enable_reg;
            end else begin
                rdata_next = 32'h00000000;
            end
        end
    end

    // output flops; every top output comes straight from here
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rdata_reg <= FLAGS_RESET;
            rvalid_reg <= 1'b0;
            request_reg <= 1'b0;
            global_reg <= 1'b0;
        end else begin
            rdata_reg <= rdata_next;
            rvalid_reg <= rvalid_next;
            request_reg <= request_next;
            global_reg <= global_next;
        end
    end

    assign reg_rdata = rdata_reg;
    assign reg_rvalid = rvalid_reg;
    assign irq_request = request_reg;
    assign irq_global = global_reg;

    // global state follows the enabled flags one edge later
    a_global_follows: assert property ( // [R13]
        @(posedge clk) disable iff (reset)
        1'b1 |=> (irq_global == $past(irq_line)))
        else $error("global state lost an enabled flag");

    // mirrors copy the phy lines with one cycle of lag
    a_mirror_phy: assert property ( // [R6] [R7]
        @(posedge clk) disable iff (reset)
        1'b1 |=> ((interrupt_flags[PHY_B_BIT] == $past(second_phy_event))
            && (interrupt_flags[PHY_A_BIT] == $past(first_phy_event))))
        else $error("phy mirror out of step");

    // a wrap from zero to all ones must leave the timer flag up
    a_timer_wrap: assert property ( // [R8]
        @(posedge clk) disable iff (reset)
        timer_wrap |=> interrupt_flags[TIMER_BIT])
        else $error("timer wrap not flagged");

    // an enabled power flag raises the request even inside a holdoff
    a_power_bypass: assert property ( // [R11]
        @(posedge clk) disable iff (reset)
        power_line |=> irq_request)
        else $error("power request held back");

    // other flags stay off the request pin during a holdoff
    a_holdoff_blocks: assert property ( // [R14]
        @(posedge clk) disable iff (reset)
        (holdoff_active_state && !power_line) |=> !irq_request)
        else $error("request leaked through holdoff");

    // pending control bits keep the power flag standing
    a_power_held: assert property ( // [R10]
        @(posedge clk) disable iff (reset)
        (interrupt_flags[POWER_BIT] && power_event_control_pending)
            |=> interrupt_flags[POWER_BIT])
        else $error("power flag cleared too early");
endmodule

/* File: rtl/isc_pkg.sv */
// constants of the interrupt status collector: offsets, bit positions, masks
// assumes byte addresses on a simple synchronous register port
package isc_pkg;
    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] FLAGS_OFFSET = 12'h058;
    localparam logic [ADDR_W-1:0] ENABLE_OFFSET = 12'h05c;

    localparam int SW_BIT = 31;
    localparam int READY_BIT = 30;
    localparam int PHY_B_BIT = 27;
    localparam int PHY_A_BIT = 26;
    localparam int TIMER_BIT = 19;
    localparam int POWER_BIT = 17;

    // flags that the host clears by writing one
    localparam logic [31:0] W1C_MASK = 32'hc00a0000;
    // flags that only mirror an outside source
    localparam logic [31:0] MIRROR_MASK = 32'h0c000000;
    // enable bits that exist for the flags above
    localparam logic [31:0] ENABLE_MASK = 32'hcc0a0000;
    localparam logic [31:0] POWER_MASK = 32'h00020000;
    localparam logic [31:0] FLAGS_RESET = 32'h00000000;
    localparam logic [31:0] ENABLE_RESET = 32'h00000000;
    localparam int TIMER_W = 16;
endpackage

/* File: test/isc_flag_bank_tb_top.sv */
// bench for the interrupt status collector: register and source traffic
// assumes one register access per cycle and a read answered one edge later
module isc_collector_tb_top
    import isc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [ADDR_W-1:0] reg_addr = FLAGS_OFFSET;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_wdata = 32'h00000000;
    logic first_phy_event = 1'b0;
    logic second_phy_event = 1'b0;
    logic [TIMER_W-1:0] timer_count = 16'h0001;
    logic power_event_detect = 1'b0;
    logic power_event_control_pending = 1'b0;
    logic holdoff_active_state = 1'b0;
    logic [31:0] reg_rdata;
    logic reg_rvalid;
    logic irq_request;
    logic irq_global;
    int error_cnt = 0;
    int compares = 0;
    // each note: read data, global state, request pin
    logic [33:0] exp_q[$];
    // model of the block's state after the latest edge
    logic [31:0] m_w1c = 32'h00000000;
    logic [31:0] m_enable = 32'h00000000;
    logic [1:0] m_phy = 2'h0;
    logic m_ready_seen = 1'b0;
    logic m_primed = 1'b0;
    logic [TIMER_W-1:0] m_prev = 16'h0000;

    isc_collector u_dut (
        .clk(clk),
        .reset(reset),
        .reg_addr(reg_addr),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_wdata(reg_wdata),
        .first_phy_event(first_phy_event),
        .second_phy_event(second_phy_event),
        .timer_count(timer_count),
        .power_event_detect(power_event_detect),
        .power_event_control_pending(power_event_control_pending),
        .holdoff_active_state(holdoff_active_state),
        .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid),
        .irq_request(irq_request),
        .irq_global(irq_global)
    );

    initial begin
        forever begin
            #20 clk = ~clk;
        end
    end

    // compare one seen value with its note
    task automatic check(input logic [33:0] seen, input logic [33:0] want);
        compares++;
        if (seen !== want) begin
            error_cnt++;
            $display("CHECK FAILED %0t seen %h want %h", $time, seen, want);
        end
    endtask

    task automatic finish_test();
        $display("compares %0d errors %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // one access plus random source levels, then one edge; called at edge + 1
    task automatic step(input logic wr, input logic rd, input logic [ADDR_W-1:0] addr,
            input logic [31:0] wdata);
        logic [31:0] flags;
        logic [31:0] active;
        logic [31:0] rexp;
        logic [31:0] set;
        logic [31:0] clear;
        int tsel;
        reg_wr = wr;
        reg_rd = rd;
        reg_addr = addr;
        reg_wdata = wdata;
        first_phy_event = ($urandom_range(1, 0) == 1);
        second_phy_event = ($urandom_range(1, 0) == 1);
        power_event_detect = ($urandom_range(7, 0) == 0);
        power_event_control_pending = ($urandom_range(1, 0) == 1);
        holdoff_active_state = ($urandom_range(3, 0) == 0);
        tsel = $urandom_range(3, 0);
        if (tsel == 0) begin
            timer_count = {TIMER_W{1'b0}};
        end else if (tsel == 1) begin
            timer_count = {TIMER_W{1'b1}};
        end else begin
            timer_count = TIMER_W'($urandom);
        end
        // what a read sees: the state before this edge
        flags = m_w1c & W1C_MASK;
        flags[PHY_B_BIT] = m_phy[1];
        flags[PHY_A_BIT] = m_phy[0];
        active = flags & m_enable;
        if (rd) begin
            if (addr == FLAGS_OFFSET) begin
                rexp = flags;
            end else if (addr == ENABLE_OFFSET) begin
                rexp = m_enable;
            end else begin
                rexp = 32'h00000000;
            end
            exp_q.push_back({rexp, |active,
                ((|active) && !holdoff_active_state) || (|(active & POWER_MASK))});
        end
        // state after this edge
        set = 32'h00000000;
        set[SW_BIT] = wr && (addr == ENABLE_OFFSET) && wdata[SW_BIT] && !m_enable[SW_BIT];
        set[READY_BIT] = !m_ready_seen;
        set[TIMER_BIT] = m_primed && (m_prev == 16'h0000) && (timer_count == 16'hffff);
        set[POWER_BIT] = power_event_detect;
        clear = 32'h00000000;
        if (wr && (addr == FLAGS_OFFSET)) begin
            clear = wdata & W1C_MASK;
            if (power_event_control_pending) begin
                clear[POWER_BIT] = 1'b0;
            end
        end
        m_w1c = (set | (m_w1c & ~clear)) & W1C_MASK;
        if (wr && (addr == ENABLE_OFFSET)) begin
            m_enable = wdata & ENABLE_MASK;
        end
        m_phy = {second_phy_event, first_phy_event};
        m_ready_seen = 1'b1;
        m_primed = 1'b1;
        m_prev = timer_count;
        @(posedge clk);
        #1;
    endtask

    // reset in mid-run; the caller lets any read answer land first
    task automatic apply_reset();
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reset = 1'b1;
        m_w1c = 32'h00000000;
        m_enable = 32'h00000000;
        m_phy = 2'h0;
        m_ready_seen = 1'b0;
        m_primed = 1'b0;
        m_prev = 16'h0000;
        repeat (2) @(posedge clk);
        #1;
        reset = 1'b0;
    endtask

    // a random mix of reads, writes and idle cycles
    task automatic random_run(input int count);
        int op;
        for (int i = 0; i < count; i++) begin
            op = $urandom_range(5, 0);
            if (op == 0) begin
                step(1'b0, 1'b1, FLAGS_OFFSET, 32'h00000000);
            end else if (op == 1) begin
                step(1'b0, 1'b1, ENABLE_OFFSET, 32'h00000000);
            end else if (op == 2) begin
                step(1'b1, 1'b0, FLAGS_OFFSET, $urandom);
            end else if (op == 3) begin
                step(1'b1, 1'b0, ENABLE_OFFSET, $urandom);
            end else if (op == 4) begin
                step(1'b0, 1'b0, FLAGS_OFFSET, 32'h00000000);
            end else begin
                step(1'b0, 1'b1, ADDR_W'($urandom) & 12'hffc, 32'h00000000);
            end
        end
    endtask

    // monitor: each answer is checked once the edge's update has landed
    always @(posedge clk) begin
        #2;
        if (reg_rvalid !== 1'b0) begin
            if (exp_q.size() == 0) begin
                error_cnt++;
                $display("CHECK FAILED %0t answer with no read outstanding", $time);
            end else begin
                check({reg_rdata, irq_global, irq_request}, exp_q.pop_front());
            end
        end
    end

    // driver: directed steps first, then random traffic around a mid-run reset
    initial begin
        void'($urandom(53));
        repeat (2) @(posedge clk);
        #1;
        reset = 1'b0;
        step(1'b0, 1'b1, FLAGS_OFFSET, 32'h00000000);
        step(1'b1, 1'b0, FLAGS_OFFSET, 32'h40000000);
        step(1'b0, 1'b1, FLAGS_OFFSET, 32'h00000000);
        step(1'b1, 1'b0, ENABLE_OFFSET, 32'hffffffff);
        step(1'b0, 1'b1, ENABLE_OFFSET, 32'h00000000);
        step(1'b0, 1'b1, FLAGS_OFFSET, 32'h00000000);
        random_run(400);
        step(1'b0, 1'b0, FLAGS_OFFSET, 32'h00000000);
        apply_reset();
        step(1'b0, 1'b1, FLAGS_OFFSET, 32'h00000000);
        random_run(200);
        step(1'b0, 1'b0, FLAGS_OFFSET, 32'h00000000);
        for (int i = 0; i < 8 && exp_q.size() > 0; i++) begin
            @(posedge clk);
        end
        if (exp_q.size() != 0) begin
            error_cnt++;
            $display("CHECK FAILED %0t reads left unanswered", $time);
        end
        finish_test();
    end
endmodule
